// ---- src/seq_out_regs.svh ----
// Constants of the sequence output allocator: parameter indices, digit fields,
// factory values and timing counts.
// Assumes inclusion by bare name from the allocator's package or module.
`ifndef SEQ_OUT_REGS_SVH
`define SEQ_OUT_REGS_SVH

// ----------------------------------------------------------------------------
// Parameter indices (operator panel select code)
// ----------------------------------------------------------------------------
`define SOA_IDX_ROUTE_A 2'h0
`define SOA_IDX_ROUTE_B 2'h1
`define SOA_IDX_ROUTE_C 2'h2
`define SOA_IDX_INVERT 2'h3

// ----------------------------------------------------------------------------
// Digit fields: four bits per digit, digit n at bits 4n+3..4n
// ----------------------------------------------------------------------------
`define SOA_DIGIT_W 4
`define SOA_NEAR_DIGIT 0
`define SOA_PSELACK_DIGIT 2

// ----------------------------------------------------------------------------
// Digit codes
// ----------------------------------------------------------------------------
`define SOA_CODE_UNUSED 4'h0
`define SOA_CODE_INVERT 4'h1

// ----------------------------------------------------------------------------
// Factory values
// ----------------------------------------------------------------------------
`define SOA_RST_ROUTE_A 16'h3211
`define SOA_RST_ROUTE_B 16'h0000
`define SOA_RST_ROUTE_C 16'h0000
`define SOA_RST_INVERT 16'h0000

// ----------------------------------------------------------------------------
// Timing: save flash on the panel display
// ----------------------------------------------------------------------------
`define SOA_CLK_MHZ 200
`define SOA_FLASH_MS 500
`define SOA_FLASH_CYCLES (`SOA_FLASH_MS * 1000 * `SOA_CLK_MHZ)

`endif

// ---- src/seq_out_pkg.sv ----
// Types of the sequence output allocator.
// Assumes seq_out_regs.svh for the numeric constants.
package seq_out_pkg;

    // ------------------------------------------------------------------------
    // Control modes reported by the drive
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_SPEED = 2'b00,
        MODE_POSITION = 2'b01,
        MODE_TORQUE = 2'b10,
        MODE_IDLE = 2'b11
    } control_mode_t;

    // Internal status signal order on the statusIn vector
    typedef enum logic [3:0] {
        SIG_POS_COMPLETE = 4'h0,
        SIG_SPEED_POSITIONING_COMPLETE = 4'h1,
        SIG_ROTATION = 4'h2,
        SIG_SERVO_READY = 4'h3,
        SIG_TORQUE_LIMIT = 4'h4,
        SIG_SPEED_LIMIT = 4'h5,
        SIG_BRAKE = 4'h6,
        SIG_ALERT = 4'h7,
        SIG_NEAR = 4'h8,
        SIG_PSEL_ACK = 4'h9
    } status_sig_t;

    typedef logic [15:0] param_word_t;

endpackage : seq_out_pkg

// ---- src/sequence_output_allocator.sv ----
// Sequence output allocator: routes internal drive status onto three output
// circuits from shadow copies of the allocation and inversion parameters.
// Assumes status and mode inputs come from logic on clk; rst_b is a power-up
// reset; powerRestart marks a supply off/on that keeps parameter memory.
`timescale 1ns/1ps
`default_nettype none
`include "seq_out_regs.svh"

module sequence_output_allocator #(
    parameter int NUM_CIRCUITS = 3,
    parameter int FLASH_CYCLES = `SOA_FLASH_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic powerRestart,
    input wire logic [1:0] controlMode,
    input wire logic [9:0] statusIn,
    input wire logic paramCommit,
    input wire logic [1:0] paramSelect,
    input wire logic [15:0] paramWriteData,
    output logic [15:0] paramReadData,
    output logic saveFlash,
    output logic [2:0] seqOut,
    output logic [2:0] outputSignalMonitor
);

    // ------------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------------
    if (NUM_CIRCUITS != 3) begin : g_bad_circuits
        $error("NUM_CIRCUITS must be 3");
    end
    if (FLASH_CYCLES < 1) begin : g_bad_flash
        $error("FLASH_CYCLES must be at least 1");
    end
    if (`SOA_DIGIT_W != 4) begin : g_bad_digit
        $error("allocation digits must be four bits wide");
    end

    // ------------------------------------------------------------------------
    // Local sizes
    // ------------------------------------------------------------------------
    // Status signals on statusIn, fixed by the allocation digits
    localparam int NUM_SIGNALS = 10;

    // All state of the block except the reset synchroniser, registered as one word
    typedef struct packed {
        logic [3:0][15:0] store;
        logic [3:0][15:0] shadow;
        logic loadPending;
        logic [31:0] flashCount;
        logic [2:0] outReg;
        logic [15:0] readData;
    } state_t;

    // ------------------------------------------------------------------------
    // Reset synchroniser
    // ------------------------------------------------------------------------
    logic [1:0] rstSync;
    logic rstN;

    // Two flops release reset in step with clk
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rstSync <= 2'b00;
        end else begin
            rstSync <= {rstSync[0], 1'b1};
        end
    end
    // Only the second flop feeds the design
    assign rstN = rstSync[1];

    // ------------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------------
    // Digit n of a parameter word
    function automatic logic [3:0] digitOf(input logic [15:0] word, input int n);
        digitOf = word[n*`SOA_DIGIT_W +: `SOA_DIGIT_W];
    endfunction : digitOf

    // Allocation digit of a status signal from the shadow words
    function automatic logic [3:0] routeDigit(input logic [3:0][15:0] sh, input int sig);
        logic [3:0] d;
        d = `SOA_CODE_UNUSED;
        if (sig < 4) begin
            d = digitOf(sh[`SOA_IDX_ROUTE_A], sig);
        end else if (sig < 8) begin
            d = digitOf(sh[`SOA_IDX_ROUTE_B], sig - 4);
        end else if (sig == 8) begin
            d = digitOf(sh[`SOA_IDX_ROUTE_C], `SOA_NEAR_DIGIT);
        end else begin
            d = digitOf(sh[`SOA_IDX_ROUTE_C], `SOA_PSELACK_DIGIT);
        end
        routeDigit = d;
    endfunction : routeDigit

    // Whether a signal is detected in the given control mode
    function automatic logic sigValid(input logic [1:0] mode, input int sig);
        logic v;
        v = 1'b1;
        unique case (sig)
            int'(seq_out_pkg::SIG_POS_COMPLETE), int'(seq_out_pkg::SIG_NEAR),
            int'(seq_out_pkg::SIG_PSEL_ACK): begin
                v = (mode == seq_out_pkg::MODE_POSITION);
            end
            int'(seq_out_pkg::SIG_SPEED_POSITIONING_COMPLETE): begin
                v = (mode == seq_out_pkg::MODE_SPEED);
            end
            int'(seq_out_pkg::SIG_SPEED_LIMIT): begin
                v = (mode == seq_out_pkg::MODE_TORQUE);
            end
            default: begin
                v = 1'b1;
            end
        endcase
        sigValid = v;
    endfunction : sigValid

    // ------------------------------------------------------------------------
    // Per-signal routing from shadow values
    // ------------------------------------------------------------------------
    state_t cur;
    state_t next_cur;
    logic [NUM_SIGNALS-1:0][3:0] sigRoute;
    logic [NUM_SIGNALS-1:0] sigLive;
    logic [2:0] muxOut;

    // Route digit and mode gate of each status signal
    for (genvar s = 0; s < NUM_SIGNALS; s++) begin : g_signal
        assign sigRoute[s] = routeDigit(cur.shadow, s);
        assign sigLive[s] = statusIn[s] & sigValid(controlMode, s);
    end

    // ------------------------------------------------------------------------
    // Output multiplexer, one OR collector per circuit
    // ------------------------------------------------------------------------
    // Shadows, not memory, feed the mux so panel edits cannot move a circuit
    for (genvar c = 0; c < NUM_CIRCUITS; c++) begin : g_circuit
        logic orAll;
        logic invertOn;

        // OR of every live signal whose digit names this circuit
        always_comb begin
            orAll = 1'b0;
            for (int s = 0; s < NUM_SIGNALS; s++) begin
                if (sigRoute[s] == 4'(c + 1)) begin
                    orAll = orAll | sigLive[s];
                end
            end
        end

        // Inversion last; brake polarity is left to the user
        assign invertOn = (digitOf(cur.shadow[`SOA_IDX_INVERT], c) == `SOA_CODE_INVERT);
        assign muxOut[c] = orAll ^ invertOn;
    end

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        next_cur = cur;
        // Panel commit writes parameter memory and starts the flash
        if (paramCommit) begin
            next_cur.store[paramSelect] = paramWriteData;
            next_cur.flashCount = 32'(FLASH_CYCLES);
        end else if (cur.flashCount != 32'h0) begin
            next_cur.flashCount = cur.flashCount - 32'h1;
        end
        // Shadows reload only at power-up or supply restart
        if (cur.loadPending || powerRestart) begin
            next_cur.shadow = next_cur.store;
            next_cur.loadPending = 1'b0;
        end
        // Circuits and monitor share one registered copy of the mux
        next_cur.outReg = muxOut;
        // Read port shows memory, so an edit reads back before a restart
        next_cur.readData = next_cur.store[paramSelect];
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    // Asynchronous reset to factory values
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            cur.store <= {`SOA_RST_INVERT, `SOA_RST_ROUTE_C, `SOA_RST_ROUTE_B,
                `SOA_RST_ROUTE_A};
            cur.shadow <= {`SOA_RST_INVERT, `SOA_RST_ROUTE_C, `SOA_RST_ROUTE_B,
                `SOA_RST_ROUTE_A};
            cur.loadPending <= 1'b1;
            cur.flashCount <= 32'h0;
            cur.outReg <= 3'h0;
            cur.readData <= 16'h0;
        end else begin
            cur <= next_cur;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign seqOut = cur.outReg;
    assign outputSignalMonitor = cur.outReg;
    assign paramReadData = cur.readData;
    assign saveFlash = (cur.flashCount != 32'h0);

endmodule : sequence_output_allocator

`default_nettype wire

// ---- tb/sequence_output_allocator_sva.sv ----
// Port checker of the sequence output allocator.
// Assumes bind onto the top module with FLASH_CYCLES handed on.
`timescale 1ns/1ps
`default_nettype none
module sequence_output_allocator_sva #(
    parameter int FLASH_CYCLES = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic powerRestart,
    input wire logic [1:0] controlMode,
    input wire logic [9:0] statusIn,
    input wire logic paramCommit,
    input wire logic [1:0] paramSelect,
    input wire logic [15:0] paramWriteData,
    input wire logic [15:0] paramReadData,
    input wire logic saveFlash,
    input wire logic [2:0] seqOut,
    input wire logic [2:0] outputSignalMonitor
);
    int upCnt;
    int sinceCommit;
    int lowCnt;
    logic touched;
    // Cycles since release, since last commit, any commit seen
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            upCnt <= 0;
            sinceCommit <= FLASH_CYCLES;
            touched <= 1'b0;
        end else begin
            upCnt <= (upCnt < 4) ? upCnt + 1 : upCnt;
            sinceCommit <= paramCommit ? 0 : sinceCommit + int'(sinceCommit < FLASH_CYCLES);
            touched <= touched | paramCommit;
        end
    end
    // Edges spent in reset; the first ones still see unknown outputs
    always_ff @(posedge clk) begin
        lowCnt <= rst_b ? 0 : ((lowCnt < 3) ? lowCnt + 1 : lowCnt);
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    AST_MONITOR_MATCH: assert property (outputSignalMonitor == seqOut)
        else $error("monitor differs from circuits");
    AST_FLASH_START: assert property (paramCommit |=> saveFlash)
        else $error("no flash after commit");
    AST_FLASH_LEN: assert property (saveFlash == (sinceCommit < FLASH_CYCLES))
        else $error("flash length wrong");
    AST_READBACK: assert property (paramCommit |=> paramReadData == $past(paramWriteData))
        else $error("stored value not read back");
    AST_ROUTE_HOLD: assert property (upCnt == 4 && !powerRestart && !$past(powerRestart)
        && $stable(statusIn) && $stable(controlMode) |=> $stable(seqOut))
        else $error("circuits moved without cause");
    AST_MODE_MASK: assert property (upCnt == 4 && controlMode == 2'h0
        && $stable(controlMode) && $stable(statusIn[9:1]) && !$past(powerRestart)
        |=> $stable(seqOut))
        else $error("invalid signal reached a circuit");
    AST_FACTORY_ROUTE: assert property (upCnt == 4 && !touched |=>
        seqOut == {$past(statusIn[3]), $past(statusIn[2]),
        $past(statusIn[0] && controlMode == 2'h1 || statusIn[1] && controlMode == 2'h0)})
        else $error("factory routing wrong");
    AST_RESET_QUIET: assert property (disable iff (1'b0) !rst_b && lowCnt >= 2 |->
        seqOut == 3'h0 && !saveFlash && paramReadData == 16'h0000)
        else $error("outputs active in reset");
    cover property (powerRestart);
    cover property (paramCommit && paramSelect == 2'h3);
    cover property (seqOut == 3'h7);
endmodule : sequence_output_allocator_sva
bind sequence_output_allocator sequence_output_allocator_sva #(.FLASH_CYCLES(FLASH_CYCLES)) chk (
    .clk(clk), .rst_b(rst_b), .powerRestart(powerRestart), .controlMode(controlMode),
    .statusIn(statusIn), .paramCommit(paramCommit), .paramSelect(paramSelect),
    .paramWriteData(paramWriteData), .paramReadData(paramReadData), .saveFlash(saveFlash),
    .seqOut(seqOut), .outputSignalMonitor(outputSignalMonitor));
`default_nettype wire

// ---- tb/host_reader.sv ----
// Host controller model: latches the three output circuits each rising edge.
// Assumes the circuits come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module host_reader (
    input wire logic clk,
    input wire logic [2:0] circuits,
    output logic [2:0] seen
);
    // Input register of the host
    always_ff @(posedge clk) begin
        seen <= circuits;
    end
endmodule : host_reader
`default_nettype wire

// ---- tb/sequence_output_allocator_test.sv ----
// Self-checking bench of the sequence output allocator with host model.
// Assumes the design, its checker and host_reader are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checkCount++; if ((g) !== (e)) begin errorCnt++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module sequence_output_allocator_test;
    logic clk = 1'b0;
    logic rst_b, powerRestart, paramCommit, saveFlash;
    logic [1:0] controlMode, paramSelect;
    logic [9:0] statusIn;
    logic [15:0] paramWriteData, paramReadData;
    logic [2:0] seqOut, monitor, seen;
    logic [15:0] mem [4];
    logic [15:0] act [4];
    int errorCnt, checkCount;
    always #2.5 clk = ~clk;
    sequence_output_allocator #(.FLASH_CYCLES(8)) DUT (.clk(clk), .rst_b(rst_b),
        .powerRestart(powerRestart), .controlMode(controlMode), .statusIn(statusIn),
        .paramCommit(paramCommit), .paramSelect(paramSelect), .paramWriteData(paramWriteData),
        .paramReadData(paramReadData), .saveFlash(saveFlash), .seqOut(seqOut),
        .outputSignalMonitor(monitor));
    host_reader host (.clk(clk), .circuits(seqOut), .seen(seen));
    // Expected circuits from active settings, mode and status
    function automatic logic [2:0] expOut(input logic [1:0] m, input logic [9:0] s);
        logic [3:0] d;
        logic ok;
        logic [2:0] r;
        r = 3'h0;
        for (int i = 0; i < 10; i++) begin
            d = i < 4 ? act[0][4*i+:4] : i < 8 ? act[1][4*(i-4)+:4] : act[2][(i-8)*8+:4];
            ok = (i == 0 || i > 7) ? m == 2'h1 : i == 1 ? m == 2'h0 : i == 5 ? m == 2'h2 : 1'b1;
            if (s[i] && ok && d >= 4'h1 && d <= 4'h3) r[d-4'h1] = 1'b1;
        end
        for (int j = 0; j < 3; j++) if (act[3][4*j+:4] == 4'h1) r[j] = ~r[j];
        return r;
    endfunction : expOut
    function automatic logic [15:0] rnd(input int hi);
        logic [15:0] w;
        for (int k = 0; k < 4; k++) w[4*k+:4] = 4'($urandom_range(0, hi));
        return w;
    endfunction : rnd
    task commit(input logic [1:0] sel, input logic [15:0] val);
        @(negedge clk);
        {paramSelect, paramWriteData, paramCommit} = {sel, val, 1'b1};
        @(negedge clk);
        paramCommit = 1'b0;
        `CHK("readback", val, paramReadData)
        `CHK("flash", 1'b1, saveFlash)
        mem[sel] = val;
    endtask : commit
    task restart;
        @(negedge clk);
        powerRestart = 1'b1;
        @(negedge clk);
        powerRestart = 1'b0;
        act = mem;
    endtask : restart
    task step(input logic [1:0] m, input logic [9:0] s);
        @(negedge clk);
        {controlMode, statusIn} = {m, s};
        repeat (2) @(negedge clk);
        `CHK("circuits", expOut(m, s), seen)
        `CHK("monitor", expOut(m, s), monitor)
    endtask : step
    task wrapUp;
        if (errorCnt == 0 && checkCount > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : wrapUp
    // Main sequence: factory, held routing, random settings
    initial begin
        logic [15:0] b, v;
        {rst_b, powerRestart, paramCommit, controlMode, statusIn} = '0;
        {paramSelect, paramWriteData, errorCnt, checkCount} = '0;
        mem = '{16'h3211, 16'h0000, 16'h0000, 16'h0000};
        act = mem;
        void'($urandom(32'h6458));
        repeat (8) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        for (int m = 0; m < 4; m++) begin
            step(2'(m), 10'h3FF);
            step(2'(m), 10'h001);
            step(2'(m), 10'($urandom));
        end
        for (int k = 0; k < 4; k++) commit(2'(k), 16'h0123);
        step(2'h1, 10'h3FF);
        repeat (12) begin
            b = rnd(4);
            v = rnd(1) & 16'h0FFF;
            if (b[11:8] inside {4'h1, 4'h2, 4'h3}) v[4*(b[11:8]-4'h1)+:4] = 4'h0;
            commit(2'h0, rnd(4));
            commit(2'h1, b);
            commit(2'h2, rnd(3));
            commit(2'h3, v);
            restart();
            repeat (4) step(2'($urandom), 10'($urandom));
        end
        wrapUp();
    end
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        errorCnt++;
        wrapUp();
    end
endmodule : sequence_output_allocator_test
`default_nettype wire
